/* core/bank_tracker.sv */
`timescale 1ns/1ps

module bank_tracker
  import ctl_pkg::*;
#(
  parameter int unsigned TRCD_CYC  = `NS2CYC(`T_RCD_NS),
  parameter int unsigned TRP_CYC   = `NS2CYC(`T_RP_NS),
  parameter int unsigned BURST_CYC = `BURST_LEN
) (
  input wire logic  clk,
  input wire logic  reset_n,
  trk_if.tracker    tif
);

  trk_state_t st_r;
  trk_state_t st_nxt;
  bank_rec_t  bank_nxt [`NUM_BANKS];
  logic       burst_end;
  logic       all_idle;

  // ****************************************************************
  // Burst bookkeeping
  // ****************************************************************
  // A burst ends on its last beat, on a terminate, or when a new column
  // command takes over the data bus.
  always_comb begin
    burst_end = st_r.burst_on && ((st_r.burst_cnt <= `CNT_W'(1)) ||
                (tif.issue && (tif.cmd == CMD_BST || tif.cmd == CMD_RD ||
                               tif.cmd == CMD_WR)));  // see (RULE5) see (RULE9)
  end

  // ****************************************************************
  // Per-bank mirror of the device state
  // ****************************************************************
  // Timers keep running whatever the device-wide state, so a bank caught
  // in a transition by a mode-register read still settles on time.
  for (genvar i = 0; i < `NUM_BANKS; i++) begin : g_bank
    always_comb begin
      bank_nxt[i] = st_r.bank[i];
      if (st_r.bank[i].cnt != '0) begin
        bank_nxt[i].cnt = st_r.bank[i].cnt - `CNT_W'(1);
      end
      case (st_r.bank[i].st)
        BK_ACTG: begin
          if (st_r.bank[i].cnt <= `CNT_W'(1)) bank_nxt[i].st = BK_ACTV;  // see (RULE4) see (RULE15)
        end
        BK_PREG: begin
          if (st_r.bank[i].cnt <= `CNT_W'(1)) bank_nxt[i].st = BK_IDLE;  // see (RULE4) see (RULE15)
        end
        default: begin
        end
      endcase
      if (burst_end && st_r.burst_bank == `BANK_W'(i)) begin
        if (st_r.bank[i].st == BK_RDAP || st_r.bank[i].st == BK_WRAP) begin
          bank_nxt[i].st  = BK_PREG;
          bank_nxt[i].cnt = `CNT_W'(TRP_CYC - 1);
        end else if (st_r.bank[i].st == BK_RDG || st_r.bank[i].st == BK_WRG) begin
          bank_nxt[i].st = BK_ACTV;  // see (RULE5) see (RULE9)
        end
      end
      if (tif.issue && (tif.bank == `BANK_W'(i) || tif.cmd == CMD_PREA)) begin
        case (tif.cmd)
          CMD_ACT: begin
            bank_nxt[i].st  = BK_ACTG;  // see (RULE6)
            bank_nxt[i].cnt = `CNT_W'(TRCD_CYC - 1);
          end
          CMD_RD: begin
            bank_nxt[i].st = tif.ap ? BK_RDAP : BK_RDG;  // see (RULE12)
          end
          CMD_WR: begin
            bank_nxt[i].st = tif.ap ? BK_WRAP : BK_WRG;  // see (RULE12)
          end
          CMD_PRE, CMD_PREA: begin
            bank_nxt[i].st  = BK_PREG;  // see (RULE13)
            bank_nxt[i].cnt = `CNT_W'(TRP_CYC - 1);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Next state assembly
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    for (int b = 0; b < `NUM_BANKS; b++) begin
      st_nxt.bank[b] = bank_nxt[b];
    end
    if (st_r.burst_cnt != '0) begin
      st_nxt.burst_cnt = st_r.burst_cnt - `CNT_W'(1);
    end
    if (burst_end) begin
      st_nxt.burst_on = 1'b0;
    end
    if (tif.issue && (tif.cmd == CMD_RD || tif.cmd == CMD_WR)) begin
      st_nxt.burst_on   = 1'b1;
      st_nxt.burst_bank = tif.bank;
      st_nxt.burst_wr   = (tif.cmd == CMD_WR);
      st_nxt.burst_ap   = tif.ap;
      st_nxt.burst_cnt  = `CNT_W'(BURST_CYC);
    end
  end

  // State register; reset leaves every bank idle and the bus quiet.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Status toward the controller
  // ****************************************************************
  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < `NUM_BANKS; b++) begin
      tif.st[b] = st_r.bank[b].st;
      if (st_r.bank[b].st != BK_IDLE) all_idle = 1'b0;
    end
  end

  assign tif.all_idle   = all_idle;
  assign tif.burst_on   = st_r.burst_on;
  assign tif.burst_bank = st_r.burst_bank;
  assign tif.burst_wr   = st_r.burst_wr;
  assign tif.burst_ap   = st_r.burst_ap;

endmodule : bank_tracker

/* core/ctl_consts.svh */
`ifndef CTL_CONSTS_SVH
`define CTL_CONSTS_SVH

// ****************************************************************
// Clock and geometry
// ****************************************************************
`define CLK_MHZ      40
`define NUM_BANKS    8
`define BANK_W       3
`define DQ_W         16
`define DM_W         2
`define BURST_LEN    4
`define BEAT_W       4
`define CNT_W        8
`define GCNT_W       16

// ****************************************************************
// Timing figures in their own units (plain defaults)
// ****************************************************************
`define T_RCD_NS     18
`define T_RP_NS      18
`define T_RRD_NS     10
`define T_RFC_NS     130
`define T_XP_NS      8
`define T_MRR_CK     2
`define T_MRW_CK     5
`define T_INIT5_US   10

// Least time in ns rounded up to whole cycles of clk.
`define NS2CYC(ns)   ((((ns) * `CLK_MHZ) + 999) / 1000)
// Time in us as whole cycles of clk.
`define US2CYC(us)   ((us) * `CLK_MHZ)

`endif

/* core/ctl_pkg.sv */
`include "ctl_consts.svh"

package ctl_pkg;

  // ****************************************************************
  // Command, bank state and device state codes
  // ****************************************************************
  typedef enum logic [3:0] {
    CMD_NOP  = 4'h0,
    CMD_ACT  = 4'h1,
    CMD_RD   = 4'h2,
    CMD_WR   = 4'h3,
    CMD_PRE  = 4'h4,
    CMD_PREA = 4'h5,
    CMD_BST  = 4'h6,
    CMD_MRR  = 4'h7,
    CMD_MRW  = 4'h8,
    CMD_RST  = 4'h9,
    CMD_REF  = 4'hA
  } cmd_t;

  typedef enum logic [2:0] {
    BK_IDLE  = 3'h0,
    BK_ACTG  = 3'h1,
    BK_ACTV  = 3'h2,
    BK_RDG   = 3'h3,
    BK_WRG   = 3'h4,
    BK_RDAP  = 3'h5,
    BK_WRAP  = 3'h6,
    BK_PREG  = 3'h7
  } bank_st_t;

  typedef enum logic [2:0] {
    G_PWRON  = 3'h0,
    G_RUN    = 3'h1,
    G_MRR    = 3'h2,
    G_MRW    = 3'h3,
    G_REF    = 3'h4,
    G_RSTG   = 3'h5,
    G_PDN    = 3'h6,
    G_PEXIT  = 3'h7
  } gst_t;

  // ****************************************************************
  // State records
  // ****************************************************************
  typedef struct packed {
    bank_st_t              st;
    logic [`CNT_W-1:0]     cnt;
  } bank_rec_t;

  typedef struct packed {
    bank_rec_t [`NUM_BANKS-1:0] bank;
    logic                       burst_on;
    logic [`BANK_W-1:0]         burst_bank;
    logic                       burst_wr;
    logic                       burst_ap;
    logic [`CNT_W-1:0]          burst_cnt;
  } trk_state_t;

  typedef struct packed {
    gst_t                           gst;
    gst_t                           mrr_ret;
    logic [`GCNT_W-1:0]             gcnt;
    logic [`CNT_W-1:0]              mcnt;
    logic [`CNT_W-1:0]              rrd;
    logic                           cke;
    logic                           cke_prev;
    cmd_t                           cmd;
    logic [`BANK_W-1:0]             bank;
    logic                           ap;
    logic [`DQ_W*`BURST_LEN-1:0]    wbuf;
    logic [`DM_W*`BURST_LEN-1:0]    mbuf;
    logic [`BEAT_W-1:0]             beats;
    logic [`DQ_W-1:0]               dq;
    logic [`DM_W-1:0]               dm;
    logic                           dq_oe;
  } host_state_t;

endpackage : ctl_pkg

/* core/lpddr2_host_ctl.sv */
// Contract
// (RULE1) Commands only with clock enable high on last and current edge, after exit wait.
// (RULE2) Never issue a bank-state and command pair outside the legal set.
// (RULE3) With bank n idle, any command may go to another bank m.
// (RULE4) Idle means precharged plus tRP; active means row open plus tRCD, nothing running.
// (RULE5) Reading or writing lasts from burst start until it completes or is terminated.
// (RULE6) Activate makes a bank active; keep tRRD between activates to different banks.
// (RULE7) Refresh, self refresh and mode-register write only with every bank idle.
// (RULE8) Burst terminate only to the bank whose burst is running, while it runs.
// (RULE9) An accepted burst terminate ends the burst and leaves that bank active.
// (RULE10) Mode-register read lasts tMRR, write tMRW; only NOP meanwhile.
// (RULE11) After a mode-register read return to idle, active or resetting; after write idle.
// (RULE12) Read and write permissions hold alike with and without auto precharge.
// (RULE13) Precharge hits one or all banks; for all, each must allow precharge.
// (RULE14) Mode-register read allowed while banks idle, active, activating or precharging.
// (RULE15) After a mode-register read, activating or precharging banks finish on time.
// (RULE16) Write after read only once the read burst completes or is terminated.
// (RULE17) Read after write only once the write burst completes or is terminated.
// (RULE18) During an auto-precharge burst other banks take any valid command.
// (RULE19) Reset is a mode-register write from power-on or all idle; enters resetting.
// (RULE20) Write data stored where mask is low, ignored where high; mask rides with data.
`timescale 1ns/1ps

module lpddr2_host_ctl
  import ctl_pkg::*;
#(
  parameter int unsigned TRCD_CYC  = `NS2CYC(`T_RCD_NS),
  parameter int unsigned TRP_CYC   = `NS2CYC(`T_RP_NS),
  parameter int unsigned TRRD_CYC  = `NS2CYC(`T_RRD_NS),
  parameter int unsigned TRFC_CYC  = `NS2CYC(`T_RFC_NS),
  parameter int unsigned TXP_CYC   = `NS2CYC(`T_XP_NS),
  parameter int unsigned TMRR_CYC  = `T_MRR_CK,
  parameter int unsigned TMRW_CYC  = `T_MRW_CK,
  parameter int unsigned TINIT_CYC = `US2CYC(`T_INIT5_US)
) (
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire cmd_t                              req_cmd,
  input  wire logic [`BANK_W-1:0]                req_bank,
  input  wire logic                              req_ap,
  input  wire logic [`DQ_W*`BURST_LEN-1:0]       req_wdata,
  input  wire logic [`DM_W*`BURST_LEN-1:0]       req_wmask,
  input  wire logic                              pd_req,
  output logic                                   busy,
  output logic                                   mem_cke,
  output cmd_t                                   mem_cmd,
  output logic [`BANK_W-1:0]                     mem_bank,
  output logic                                   mem_ap,
  output logic [`DQ_W-1:0]                       mem_dq_o,
  output logic                                   mem_dq_oe,
  output logic [`DM_W-1:0]                       mem_dm
);

  host_state_t st_r;
  host_state_t st_nxt;
  trk_if       tif ();

  logic        legal;
  logic        issue;
  logic        cke_ok;
  logic        run;
  logic        quiet;
  logic        pd_go;
  logic        prea_ok;
  logic        mrr_ok;
  bank_st_t    tgt;

  // ****************************************************************
  // Bank state mirror
  // ****************************************************************
  bank_tracker #(
    .TRCD_CYC  (TRCD_CYC),
    .TRP_CYC   (TRP_CYC),
    .BURST_CYC (`BURST_LEN)
  ) u_tracker (
    .clk     (clk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  assign tif.issue = issue;
  assign tif.cmd   = req_cmd;
  assign tif.bank  = req_bank;
  assign tif.ap    = req_ap;

  // ****************************************************************
  // Whole-device conditions
  // ****************************************************************
  // Commands need the clock enable seen high on two successive edges; the
  // gap after power-down exit is kept by the separate G_PEXIT wait.
  always_comb begin
    cke_ok = st_r.cke && st_r.cke_prev;  // see (RULE1)
    run    = (st_r.gst == G_RUN) && cke_ok;  // see (RULE10)
    quiet  = tif.all_idle && !tif.burst_on;
    tgt    = tif.st[req_bank];
    pd_go  = run && pd_req && quiet && (st_r.rrd == '0);
  end

  // Multi-bank checks: all-bank precharge and mode-register read look at
  // every bank, not only the one addressed.
  always_comb begin
    prea_ok = !tif.burst_on;
    mrr_ok  = !tif.burst_on;
    for (int b = 0; b < `NUM_BANKS; b++) begin
      if (tif.st[b] != BK_IDLE && tif.st[b] != BK_ACTV) begin
        prea_ok = 1'b0;  // see (RULE13)
      end
      if (tif.st[b] == BK_RDG || tif.st[b] == BK_WRG ||
          tif.st[b] == BK_RDAP || tif.st[b] == BK_WRAP) begin
        mrr_ok = 1'b0;  // see (RULE14)
      end
    end
  end

  // ****************************************************************
  // Legality of the pending request
  // ****************************************************************
  // Anything not matched below stays refused; the request simply waits
  // with ready low, so a request that can never become legal must be
  // withdrawn by the user.
  always_comb begin
    legal = 1'b0;  // see (RULE2)
    case (req_cmd)
      CMD_NOP: begin
        legal = 1'b1;
      end
      CMD_ACT: begin
        legal = run && tgt == BK_IDLE && st_r.rrd == '0;  // see (RULE3) see (RULE6)
      end
      CMD_RD: begin
        // Same-direction bursts may chain; a write in flight must finish or
        // be terminated first. Banks in auto-precharge bursts are not
        // touched, other banks are free to take the read.
        legal = run && (tgt == BK_ACTV || tgt == BK_RDG || tgt == BK_WRG) &&
                !(tif.burst_on && tif.burst_wr);  // see (RULE17) see (RULE18) see (RULE12)
      end
      CMD_WR: begin
        legal = run && (tgt == BK_ACTV || tgt == BK_RDG || tgt == BK_WRG) &&
                !(tif.burst_on && !tif.burst_wr);  // see (RULE16) see (RULE18) see (RULE12)
      end
      CMD_PRE: begin
        legal = run && (tgt == BK_IDLE || tgt == BK_ACTV);  // see (RULE13)
      end
      CMD_PREA: begin
        legal = run && prea_ok;  // see (RULE13)
      end
      CMD_BST: begin
        // Auto-precharge bursts cannot be cut short, so they are excluded.
        legal = run && tif.burst_on && !tif.burst_ap &&
                req_bank == tif.burst_bank;  // see (RULE8)
      end
      CMD_MRR: begin
        legal = (run && mrr_ok) ||
                (st_r.gst == G_RSTG && cke_ok);  // see (RULE14)
      end
      CMD_MRW, CMD_REF: begin
        legal = run && quiet;  // see (RULE7)
      end
      CMD_RST: begin
        legal = cke_ok && (st_r.gst == G_PWRON ||
                           (st_r.gst == G_RUN && quiet));  // see (RULE19)
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    if (pd_go) legal = 1'b0;
  end

  assign req_ready = legal;
  assign issue     = req_valid && legal;

  // ****************************************************************
  // Device-wide sequencer
  // ****************************************************************
  // Timed waits load the count less one and leave at one, so the next
  // command, bar a mode-register read inside the reset wait, lands no
  // earlier than the full wait after the one that started it (two cycles at the least).
  always_comb begin
    st_nxt          = st_r;
    st_nxt.cke_prev = st_r.cke;
    if (st_r.gcnt != '0) st_nxt.gcnt = st_r.gcnt - `GCNT_W'(1);
    if (st_r.mcnt != '0) st_nxt.mcnt = st_r.mcnt - `CNT_W'(1);
    if (st_r.rrd != '0)  st_nxt.rrd  = st_r.rrd - `CNT_W'(1);
    case (st_r.gst)
      G_PWRON: begin
        st_nxt.cke = 1'b1;
      end
      G_RUN: begin
        if (pd_go) begin
          st_nxt.gst = G_PDN;  // see (RULE1)
          st_nxt.cke = 1'b0;
        end
      end
      G_MRR: begin
        if (st_r.mcnt <= `CNT_W'(1)) st_nxt.gst = st_r.mrr_ret;  // see (RULE10) see (RULE11)
      end
      G_MRW, G_REF: begin
        if (st_r.mcnt <= `CNT_W'(1)) st_nxt.gst = G_RUN;  // see (RULE10) see (RULE11)
      end
      G_RSTG: begin
        if (st_r.gcnt <= `GCNT_W'(1)) st_nxt.gst = G_RUN;
      end
      G_PDN: begin
        if (!pd_req) begin
          st_nxt.gst  = G_PEXIT;
          st_nxt.cke  = 1'b1;
          st_nxt.gcnt = `GCNT_W'(TXP_CYC - 1);
        end
      end
      G_PEXIT: begin
        if (st_r.gcnt <= `GCNT_W'(1)) st_nxt.gst = G_RUN;  // see (RULE1)
      end
      default: begin
        st_nxt.gst = G_PWRON;
      end
    endcase

    // Accepted commands start their device-wide effects here.
    if (issue) begin
      case (req_cmd)
        CMD_ACT: begin
          st_nxt.rrd = `CNT_W'(TRRD_CYC - 1);  // see (RULE6)
        end
        CMD_MRR: begin
          st_nxt.gst     = G_MRR;  // see (RULE10)
          st_nxt.mrr_ret = st_r.gst;  // see (RULE11)
          st_nxt.mcnt    = `CNT_W'(TMRR_CYC - 1);
        end
        CMD_MRW: begin
          st_nxt.gst  = G_MRW;  // see (RULE10)
          st_nxt.mcnt = `CNT_W'(TMRW_CYC - 1);
        end
        CMD_REF: begin
          st_nxt.gst  = G_REF;
          st_nxt.mcnt = `CNT_W'(TRFC_CYC - 1);
        end
        CMD_RST: begin
          st_nxt.gst  = G_RSTG;  // see (RULE19)
          st_nxt.gcnt = `GCNT_W'(TINIT_CYC - 1);
        end
        default: begin
        end
      endcase
    end

    // Command pins: the accepted command for one cycle, NOP otherwise.
    st_nxt.cmd  = issue ? req_cmd : CMD_NOP;  // see (RULE10)
    st_nxt.bank = issue ? req_bank : st_r.bank;
    st_nxt.ap   = issue && req_ap;

    // Write data path: beat zero goes out in the same cycle as the command
    // and each mask bit travels in the same cycle as its data byte, so the
    // device stores a byte only where its mask is low.
    st_nxt.dq_oe = 1'b0;
    if (issue && req_cmd == CMD_WR) begin
      st_nxt.dq    = req_wdata[`DQ_W-1:0];  // see (RULE20)
      st_nxt.dm    = req_wmask[`DM_W-1:0];  // see (RULE20)
      st_nxt.wbuf  = req_wdata >> `DQ_W;
      st_nxt.mbuf  = req_wmask >> `DM_W;
      st_nxt.beats = `BEAT_W'(`BURST_LEN - 1);
      st_nxt.dq_oe = 1'b1;
    end else if (issue && (req_cmd == CMD_BST || req_cmd == CMD_RD)) begin
      st_nxt.beats = '0;  // see (RULE9) see (RULE17)
    end else if (st_r.beats != '0) begin
      st_nxt.dq    = st_r.wbuf[`DQ_W-1:0];
      st_nxt.dm    = st_r.mbuf[`DM_W-1:0];
      st_nxt.wbuf  = st_r.wbuf >> `DQ_W;
      st_nxt.mbuf  = st_r.mbuf >> `DM_W;
      st_nxt.beats = st_r.beats - `BEAT_W'(1);
      st_nxt.dq_oe = 1'b1;
    end
  end

  // State register; reset lands in power-on with the clock enable low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign busy      = (st_r.gst != G_RUN);
  assign mem_cke   = st_r.cke;
  assign mem_cmd   = st_r.cmd;
  assign mem_bank  = st_r.bank;
  assign mem_ap    = st_r.ap;
  assign mem_dq_o  = st_r.dq;
  assign mem_dq_oe = st_r.dq_oe;
  assign mem_dm    = st_r.dm;

endmodule : lpddr2_host_ctl

/* core/trk_if.sv */
`timescale 1ns/1ps

interface trk_if
  import ctl_pkg::*;
  ();
  logic                           issue;
  cmd_t                           cmd;
  logic [`BANK_W-1:0]             bank;
  logic                           ap;
  bank_st_t [`NUM_BANKS-1:0]      st;
  logic                           all_idle;
  logic                           burst_on;
  logic [`BANK_W-1:0]             burst_bank;
  logic                           burst_wr;
  logic                           burst_ap;

  modport ctl (
    output issue, cmd, bank, ap,
    input  st, all_idle, burst_on, burst_bank, burst_wr, burst_ap
  );
  modport tracker (
    input  issue, cmd, bank, ap,
    output st, all_idle, burst_on, burst_bank, burst_wr, burst_ap
  );
endinterface : trk_if

/* tb/lpddr2_dev_model.sv */
`timescale 1ns/1ps

module lpddr2_dev_model
  import ctl_pkg::*;
(
  input wire logic               clk,
  input wire logic               mem_cke,
  input wire cmd_t               mem_cmd,
  input wire logic [`BANK_W-1:0] mem_bank,
  input wire logic [`DQ_W-1:0]   mem_dq_o,
  input wire logic               mem_dq_oe,
  input wire logic [`DM_W-1:0]   mem_dm
);
  // Cells start with a known pattern so that a masked byte stays visible.
  logic [`DQ_W-1:0] store [`BURST_LEN];
  logic [1:0]       beat;
  bank_st_t         bank_st [`NUM_BANKS];
  initial begin
    for (int i = 0; i < `BURST_LEN; i++)
      store[i] = 16'h5A5A;
  end

  // Timing is the controller's duty, so the model only follows states and data.
  always @(posedge clk) begin
    if (mem_cke) begin
      beat <= (mem_cmd == CMD_WR) ? 2'h1 : beat + 2'h1;
      for (int i = 0; i < `DM_W; i++) begin
        if (mem_dq_oe && !mem_dm[i]) begin
          store[(mem_cmd == CMD_WR) ? 2'h0 : beat][8*i+:8] <= mem_dq_o[8*i+:8];
        end
      end
      case (mem_cmd)
        CMD_ACT: bank_st[mem_bank] <= BK_ACTV;
        CMD_RD: bank_st[mem_bank] <= BK_RDG;
        CMD_WR: bank_st[mem_bank] <= BK_WRG;
        CMD_BST: bank_st[mem_bank] <= BK_ACTV;
        CMD_PRE: bank_st[mem_bank] <= BK_IDLE;
        CMD_PREA, CMD_MRW, CMD_RST: bank_st <= '{default: BK_IDLE};
        default: ; // Register reads leave banks as they were
      endcase
    end
  end
endmodule : lpddr2_dev_model

/* tb/lpddr2_host_chk.sv */
`timescale 1ns/1ps

module lpddr2_host_chk
  import ctl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire cmd_t req_cmd,
  input wire logic busy,
  input wire logic mem_cke,
  input wire cmd_t mem_cmd,
  input wire logic mem_dq_oe
);
  // One clock domain, so the clock and the reset are given once for all properties.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic take;
  assign take = req_valid && req_ready;

  // Each property ties a pin to its cause with the exact cycle figure.
  chk_cmd_taken: assert property (take |=> mem_cmd == $past(req_cmd))
    else $error("taken request missing on command pins");
  chk_cke_both: assert property (take && req_cmd != CMD_NOP |-> mem_cke && $past(mem_cke))
    else $error("command taken without clock enable on two edges");
  chk_busy_refuse: assert property (busy && req_cmd != CMD_NOP && req_cmd != CMD_MRR
    && req_cmd != CMD_RST |-> !req_ready) else $error("request accepted while busy");
  chk_mrr_quiet: assert property (mem_cmd == CMD_MRR |-> busy ##1 mem_cmd == CMD_NOP)
    else $error("register read not followed by idle cycle");
  chk_mrw_quiet: assert property (mem_cmd == CMD_MRW |=> (mem_cmd == CMD_NOP)[*4])
    else $error("register write interrupted");
  chk_act_gap: assert property (mem_cmd == CMD_ACT |=> mem_cmd != CMD_ACT)
    else $error("activates too close");
  chk_wr_data: assert property (mem_cmd == CMD_WR |-> mem_dq_oe)
    else $error("write without first beat");
  chk_burst_end: assert property (mem_cmd == CMD_WR ##1 (mem_cmd == CMD_NOP)[*4]
    |-> !mem_dq_oe) else $error("write burst too long");
  chk_bst_cut: assert property (mem_cmd == CMD_BST ##1 mem_cmd != CMD_WR |-> !mem_dq_oe)
    else $error("terminated burst still driven");
  chk_pdn_busy: assert property (!mem_cke |-> busy)
    else $error("clock enable low while not busy");

  cover property (mem_cmd == CMD_BST);
  cover property (mem_cmd == CMD_MRW);
  cover property (!mem_cke);
endmodule : lpddr2_host_chk

bind lpddr2_host_ctl lpddr2_host_chk u_chk (.clk, .reset_n, .req_valid, .req_ready, .req_cmd,
  .busy, .mem_cke, .mem_cmd, .mem_dq_oe);

/* tb/lpddr2_host_ctl_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module lpddr2_host_ctl_tb_top;
  import ctl_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ap = 1'b0;
  logic pd_req = 1'b0;
  cmd_t req_cmd = CMD_NOP;
  logic [`BANK_W-1:0] req_bank = 3'h0;
  logic [`DQ_W*`BURST_LEN-1:0] req_wdata = 64'h4444_3333_2222_1111;
  logic [`DM_W*`BURST_LEN-1:0] req_wmask = 8'h24;
  logic req_ready, busy, mem_cke, mem_ap, mem_dq_oe;
  cmd_t mem_cmd;
  logic [`BANK_W-1:0] mem_bank;
  logic [`DQ_W-1:0] mem_dq_o;
  logic [`DM_W-1:0] mem_dm;
  int errors = 0;
  int n_tests = 0;

  always #12.5 clk = ~clk;

  // Init wait shortened for a brief run; activate gap widened to two cycles so it shows.
  lpddr2_host_ctl #(.TINIT_CYC(8), .TRRD_CYC(2)) u_dut (.clk, .reset_n, .req_valid,
    .req_ready, .req_cmd, .req_bank, .req_ap, .req_wdata, .req_wmask, .pd_req, .busy,
    .mem_cke, .mem_cmd, .mem_bank, .mem_ap, .mem_dq_o, .mem_dq_oe, .mem_dm);
  lpddr2_dev_model u_mem (.clk, .mem_cke, .mem_cmd, .mem_bank, .mem_dq_o, .mem_dq_oe, .mem_dm);

  task automatic drive(input cmd_t c, input logic [`BANK_W-1:0] b);
    req_cmd = c;
    req_bank = b;
    req_valid = 1'b1;
    #1;
  endtask : drive

  // Hold the request until it is legal, then see it reach the command pins.
  task automatic send(input cmd_t c, input logic [`BANK_W-1:0] b);
    int k;
    k = 0;
    drive(c, b);
    while (req_ready !== 1'b1 && k < 500) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    `CHK("mem_cmd", c, mem_cmd)
    `CHK("mem_bank", b, mem_bank)
  endtask : send

  // An illegal request must meet ready low; it is withdrawn before any edge.
  task automatic refuse(input cmd_t c, input logic [`BANK_W-1:0] b);
    drive(c, b);
    `CHK("req_ready", 1'b0, req_ready)
    req_valid = 1'b0;
  endtask : refuse

  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 1000) begin
      @(negedge clk);
      k++;
    end
    `CHK("busy", 1'b0, busy)
  endtask : wait_idle

  task automatic t_init;
    `CHK("mem_cke", 1'b0, mem_cke)
    refuse(CMD_ACT, 3'h0);
    send(CMD_RST, 3'h0);
    `CHK("busy", 1'b1, busy)
    wait_idle();
  endtask : t_init

  task automatic t_banks;
    send(CMD_ACT, 3'h0);
    refuse(CMD_ACT, 3'h1);
    send(CMD_ACT, 3'h1);
    send(CMD_MRR, 3'h2);
    `CHK("busy", 1'b1, busy)
    refuse(CMD_RD, 3'h0);
    wait_idle();
  endtask : t_banks

  task automatic t_write;
    logic [15:0] exp_w [4];
    exp_w = '{16'h1111, 16'h225A, 16'h5A33, 16'h4444};
    send(CMD_WR, 3'h1);
    refuse(CMD_RD, 3'h0);
    for (int k = 0; k < 4; k++) begin
      `CHK("mem_dq_o", req_wdata[16*k+:16], mem_dq_o)
      `CHK("mem_dm", req_wmask[2*k+:2], mem_dm)
      @(negedge clk);
    end
    `CHK("mem_dq_oe", 1'b0, mem_dq_oe)
    for (int k = 0; k < 4; k++)
      `CHK("stored", exp_w[k], u_mem.store[k])
  endtask : t_write

  // A cut write lets a read follow at once; a finished read leaves nothing to cut.
  task automatic t_bst;
    send(CMD_WR, 3'h0);
    send(CMD_BST, 3'h0);
    send(CMD_RD, 3'h0);
    `CHK("mem_dq_oe", 1'b0, mem_dq_oe)
    `CHK("bank_st", BK_ACTV, u_mem.bank_st[0])
    refuse(CMD_WR, 3'h1);
    repeat (6) @(negedge clk);
    refuse(CMD_BST, 3'h0);
    req_ap = 1'b1;
    send(CMD_WR, 3'h1);
    `CHK("mem_ap", 1'b1, mem_ap)
    req_ap = 1'b0;
    send(CMD_WR, 3'h0);
  endtask : t_bst

  task automatic t_idle;
    refuse(CMD_MRW, 3'h0);
    send(CMD_PREA, 3'h0);
    send(CMD_MRW, 3'h0);
    wait_idle();
    send(CMD_REF, 3'h0);
    wait_idle();
    send(CMD_ACT, 3'h2);
    send(CMD_PRE, 3'h2);
    send(CMD_NOP, 3'h0);
  endtask : t_idle

  task automatic t_pd;
    int k;
    k = 0;
    pd_req = 1'b1;
    while (mem_cke !== 1'b0 && k < 50) begin
      @(negedge clk);
      k++;
    end
    `CHK("mem_cke", 1'b0, mem_cke)
    refuse(CMD_ACT, 3'h0);
    pd_req = 1'b0;
    wait_idle();
    send(CMD_ACT, 3'h0);
  endtask : t_pd

  task automatic complete_run;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // Reset spans four cycles and is released off the sampling edge.
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    t_init();
    t_banks();
    t_write();
    t_bst();
    t_idle();
    t_pd();
    complete_run();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #100us;
    errors++;
    complete_run();
  end
endmodule : lpddr2_host_ctl_tb_top
